// file: hw/dsp_bank_pkg.sv
package dsp_bank_pkg;
    // ************************************************************
    // printed register indices (byte address = index * 4)
    // ************************************************************
    localparam logic [7:0] idx_phase_lo = 8'h24;
    localparam logic [7:0] idx_phase_hi = 8'h25;
    localparam logic [7:0] idx_dc_lo = 8'h26;
    localparam logic [7:0] idx_dc_hi = 8'h27;
    localparam logic [7:0] idx_factory = 8'h28;
    localparam logic [7:0] idx_tx_level = 8'h29;
    localparam logic [7:0] idx_noise_lo = 8'h2A;
    localparam logic [7:0] idx_noise_hi = 8'h2B;
    localparam logic [7:0] idx_hold_lo = 8'h2C;
    localparam logic [7:0] idx_hold_hi = 8'h2D;
    localparam logic [7:0] idx_lock = 8'h2E;
    localparam logic [7:0] idx_upper_lo = 8'h30;
    localparam logic [7:0] idx_upper_hi = 8'h31;
    localparam logic [7:0] idx_lower_lo = 8'h32;
    localparam logic [7:0] idx_lower_hi = 8'h33;
    // own registers: control, event status, clear, enable
    localparam logic [7:0] idx_control = 8'h40;
    localparam logic [7:0] idx_status = 8'h41;
    localparam logic [7:0] idx_clear = 8'h42;
    localparam logic [7:0] idx_enable = 8'h43;
    // ************************************************************
    // field layout and constants
    // ************************************************************
    localparam int gain_lsb = 2;
    localparam int gain_msb = 5;
    localparam int lock_msb = 6;
    localparam int ev_sync = 0;
    localparam int ev_high = 1;
    localparam int ev_low = 2;
    localparam int ev_width = 3;
    localparam int ctl_auto_sync = 0;
    localparam logic [2:0] pause_symbols = 3'h5;
    localparam logic [7:0] window_len = 8'h80;
    localparam logic [7:0] desync_len = 8'h17;
endpackage : dsp_bank_pkg

// file: hw/dsp_offset_threshold_bank.sv
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// RULE1 - subtract signed phase offset from phase detector after meter tap, before loop filter
// RULE2 - subtract signed receive_dc_correction at format conversion output, ahead of level meters
// RULE3 - present read-only signed 4-bit factory gain in bits 5..2; writes ignored
// RULE4 - apply signed 4-bit transmit gain from bits 5..2, 1000 lowest, 0111 highest
// RULE5 - host copies factory value into gain field or writes its own at start
// RULE6 - count slicer error samples whose magnitude strictly exceeds noise limit
// RULE7 - force predictor correction to zero for 5 symbols after last exceedance
// RULE8 - predictor coefficients keep updating during a pause
// RULE9 - unsigned 7-bit lock limit; sync passes when match count strictly exceeds it
// RULE10 - lock limit ignored while automatic sync mode is off
// RULE11 - set high alarm flag when far-end level strictly above upper limit
// RULE12 - set low alarm flag when far-end level strictly below lower limit
// RULE13 - host programs thresholds only with non-negative values up to 7FFF
// RULE14 - in auto sync set sync flag once match count exceeds limit within 128 cycles; code counts a 128-symbol window after 23 settle symbols
// RULE15 - two-byte registers: low byte at lower index, high byte next, one 16-bit value
module dsp_offset_threshold_bank (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] factory_gain,
    input wire logic sym_strobe,
    input wire logic [15:0] phase_detect,
    output logic [15:0] phase_to_loop,
    input wire logic [15:0] rx_format,
    output logic [15:0] rx_corrected,
    output logic [3:0] tx_gain_code,
    input wire logic [15:0] slicer_error,
    output logic noise_hit,
    output logic predictor_pause,
    input wire logic match_bit,
    output logic auto_sync_mode,
    input wire logic [15:0] far_end_level,
    output logic irq
);
    // ************************************************************
    // storage
    // ************************************************************
    logic [15:0] phase_ff, dc_ff, noise_ff, hold_ff, upper_ff, lower_ff;
    logic [7:0] tx_level_ff;
    logic [6:0] lock_ff;
    logic [3:0] factory_ff;
    logic [7:0] control_ff;
    logic [2:0] status_ff, enable_ff;
    logic [2:0] pause_cnt_ff;
    logic [7:0] phase_cnt_ff;
    logic [7:0] match_cnt_ff;
    logic searching_ff;
    logic [15:0] phase_out_ff, rx_out_ff;
    logic [3:0] fact_sync1_ff, fact_sync2_ff;
    logic strap_taken_ff;
    logic [31:0] prdata_ff;

    // ************************************************************
    // helpers
    // ************************************************************
    // magnitude of a signed sample, saturating the most negative code
    function automatic logic [15:0] mag(input logic [15:0] v);
        logic [15:0] n;
        n = 16'(~v + 16'h0001);
        if (!v[15]) begin
            mag = v;
        end else if (n[15]) begin
            mag = 16'h7FFF;
        end else begin
            mag = n;
        end
    endfunction : mag

    // merge one byte into the low or high half of a word
    function automatic logic [15:0] put_byte(input logic [15:0] old, input logic hi,
                                             input logic [7:0] b);
        put_byte = hi ? {b, old[7:0]} : {old[15:8], b};
    endfunction : put_byte

    logic access, wr, rd;
    logic [7:0] idx;
    logic [15:0] err_mag;
    logic [2:0] events;
    logic [7:0] nxt_match_cnt;
    assign access = psel && penable;
    assign wr = access && pwrite;
    assign rd = access && !pwrite;
    assign idx = paddr[9:2];
    assign err_mag = mag(slicer_error);
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    // ************************************************************
    // factory strap capture after reset release
    // ************************************************************
    // strap is synchronised then followed until the first control register write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fact_sync1_ff <= 4'h0;
            fact_sync2_ff <= 4'h0;
            factory_ff <= 4'h0;
            strap_taken_ff <= 1'b0;
        end else begin
            fact_sync1_ff <= factory_gain;
            fact_sync2_ff <= fact_sync1_ff;
            strap_taken_ff <= 1'b1;
            if (!strap_taken_ff || !control_ff[7]) begin
                factory_ff <= fact_sync2_ff; // RULE3
            end
        end
    end

    // ************************************************************
    // register writes
    // ************************************************************
    // two-byte registers assemble from low and high indices
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_ff <= 16'h0000;
            dc_ff <= 16'h0000;
            noise_ff <= 16'h0000;
            hold_ff <= 16'h0000;
            upper_ff <= 16'h0000;
            lower_ff <= 16'h0000;
            tx_level_ff <= 8'h00;
            lock_ff <= 7'h00;
            control_ff <= 8'h00;
            enable_ff <= 3'h0;
        end else if (wr) begin
            case (idx)
                dsp_bank_pkg::idx_phase_lo, dsp_bank_pkg::idx_phase_hi: begin
                    phase_ff <= put_byte(phase_ff, idx[0], pwdata[7:0]); // RULE15
                end
                dsp_bank_pkg::idx_dc_lo, dsp_bank_pkg::idx_dc_hi: begin
                    dc_ff <= put_byte(dc_ff, idx[0], pwdata[7:0]); // RULE15
                end
                dsp_bank_pkg::idx_noise_lo, dsp_bank_pkg::idx_noise_hi: begin
                    noise_ff <= put_byte(noise_ff, idx[0], pwdata[7:0]);
                end
                dsp_bank_pkg::idx_hold_lo, dsp_bank_pkg::idx_hold_hi: begin
                    hold_ff <= put_byte(hold_ff, idx[0], pwdata[7:0]);
                end
                dsp_bank_pkg::idx_upper_lo, dsp_bank_pkg::idx_upper_hi: begin
                    upper_ff <= put_byte(upper_ff, idx[0], pwdata[7:0]);
                end
                dsp_bank_pkg::idx_lower_lo, dsp_bank_pkg::idx_lower_hi: begin
                    lower_ff <= put_byte(lower_ff, idx[0], pwdata[7:0]);
                end
                dsp_bank_pkg::idx_tx_level: begin
                    tx_level_ff <= {2'h0, pwdata[dsp_bank_pkg::gain_msb:dsp_bank_pkg::gain_lsb],
                                    2'h0}; // RULE4
                end
                dsp_bank_pkg::idx_lock: begin
                    lock_ff <= pwdata[dsp_bank_pkg::lock_msb:0]; // RULE9
                end
                dsp_bank_pkg::idx_control: begin
                    control_ff <= {1'b1, 6'h00, pwdata[dsp_bank_pkg::ctl_auto_sync]};
                end
                dsp_bank_pkg::idx_enable: begin
                    enable_ff <= pwdata[dsp_bank_pkg::ev_width-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // ************************************************************
    // datapath corrections
    // ************************************************************
    // offsets subtracted on every cycle, registered outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_out_ff <= 16'h0000;
            rx_out_ff <= 16'h0000;
        end else begin
            phase_out_ff <= 16'(phase_detect - phase_ff); // RULE1
            rx_out_ff <= 16'(rx_format - dc_ff); // RULE2
        end
    end
    assign phase_to_loop = phase_out_ff;
    assign rx_corrected = rx_out_ff;
    assign tx_gain_code = tx_level_ff[dsp_bank_pkg::gain_msb:dsp_bank_pkg::gain_lsb]; // RULE4
    assign noise_hit = sym_strobe && (err_mag > noise_ff); // RULE6

    // ************************************************************
    // predictor pause
    // ************************************************************
    // counter reloads on every exceedance; only correction is gated
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pause_cnt_ff <= 3'h0;
        end else if (sym_strobe) begin
            if (err_mag > hold_ff) begin
                pause_cnt_ff <= dsp_bank_pkg::pause_symbols; // RULE7
            end else if (pause_cnt_ff != 3'h0) begin
                pause_cnt_ff <= 3'(pause_cnt_ff - 3'h1);
            end
        end
    end
    assign predictor_pause = (pause_cnt_ff != 3'h0); // RULE7 RULE8

    // ************************************************************
    // automatic descrambler sync search
    // ************************************************************
    // 23 settle symbols then a 128-symbol compare window, repeated
    assign auto_sync_mode = control_ff[dsp_bank_pkg::ctl_auto_sync];
    // match count including the sample on this strobe
    assign nxt_match_cnt = 8'(match_cnt_ff + {7'h00, match_bit});
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_cnt_ff <= 8'h00;
            match_cnt_ff <= 8'h00;
            searching_ff <= 1'b0;
        end else if (!auto_sync_mode || status_ff[dsp_bank_pkg::ev_sync]) begin
            phase_cnt_ff <= 8'h00; // RULE10
            match_cnt_ff <= 8'h00;
            searching_ff <= 1'b0;
        end else if (sym_strobe) begin
            phase_cnt_ff <= 8'(phase_cnt_ff + 8'h01);
            if (!searching_ff && phase_cnt_ff == 8'(dsp_bank_pkg::desync_len - 8'h01)) begin
                searching_ff <= 1'b1;
                phase_cnt_ff <= 8'h00;
            end else if (searching_ff) begin
                match_cnt_ff <= nxt_match_cnt;
                // the last window sample may still pass, so keep its count then
                if (phase_cnt_ff == 8'(dsp_bank_pkg::window_len - 8'h01)
                    && nxt_match_cnt <= {1'b0, lock_ff}) begin
                    searching_ff <= 1'b0; // RULE14
                    phase_cnt_ff <= 8'h00;
                    match_cnt_ff <= 8'h00;
                end
            end
        end
    end

    // ************************************************************
    // events and interrupt
    // ************************************************************
    assign events[dsp_bank_pkg::ev_sync] = auto_sync_mode && searching_ff
                                           && (match_cnt_ff > {1'b0, lock_ff}); // RULE9 RULE14
    assign events[dsp_bank_pkg::ev_high] = $signed(far_end_level) > $signed(upper_ff); // RULE11
    assign events[dsp_bank_pkg::ev_low] = $signed(far_end_level) < $signed(lower_ff); // RULE12

    // sticky flags, set wins over clear; sync cannot clear while auto mode on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_ff <= 3'h0;
        end else begin
            status_ff[dsp_bank_pkg::ev_sync] <= events[dsp_bank_pkg::ev_sync]
                | (status_ff[dsp_bank_pkg::ev_sync] & ~(wr && idx == dsp_bank_pkg::idx_clear
                   && pwdata[dsp_bank_pkg::ev_sync] && !auto_sync_mode));
            status_ff[dsp_bank_pkg::ev_high] <= events[dsp_bank_pkg::ev_high]
                | (status_ff[dsp_bank_pkg::ev_high] & ~(wr && idx == dsp_bank_pkg::idx_clear
                   && pwdata[dsp_bank_pkg::ev_high])); // RULE11
            status_ff[dsp_bank_pkg::ev_low] <= events[dsp_bank_pkg::ev_low]
                | (status_ff[dsp_bank_pkg::ev_low] & ~(wr && idx == dsp_bank_pkg::idx_clear
                   && pwdata[dsp_bank_pkg::ev_low])); // RULE12
        end
    end
    assign irq = |(status_ff & enable_ff);

    // ************************************************************
    // read data
    // ************************************************************
    // byte registers in the low bits, unmapped reads zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr[9:2])
                dsp_bank_pkg::idx_phase_lo: prdata_ff <= {24'h0, phase_ff[7:0]};
                dsp_bank_pkg::idx_phase_hi: prdata_ff <= {24'h0, phase_ff[15:8]};
                dsp_bank_pkg::idx_dc_lo: prdata_ff <= {24'h0, dc_ff[7:0]};
                dsp_bank_pkg::idx_dc_hi: prdata_ff <= {24'h0, dc_ff[15:8]};
                dsp_bank_pkg::idx_factory: prdata_ff <= {26'h0, factory_ff, 2'h0}; // RULE3
                dsp_bank_pkg::idx_tx_level: prdata_ff <= {24'h0, tx_level_ff};
                dsp_bank_pkg::idx_noise_lo: prdata_ff <= {24'h0, noise_ff[7:0]};
                dsp_bank_pkg::idx_noise_hi: prdata_ff <= {24'h0, noise_ff[15:8]};
                dsp_bank_pkg::idx_hold_lo: prdata_ff <= {24'h0, hold_ff[7:0]};
                dsp_bank_pkg::idx_hold_hi: prdata_ff <= {24'h0, hold_ff[15:8]};
                dsp_bank_pkg::idx_lock: prdata_ff <= {25'h0, lock_ff};
                dsp_bank_pkg::idx_upper_lo: prdata_ff <= {24'h0, upper_ff[7:0]};
                dsp_bank_pkg::idx_upper_hi: prdata_ff <= {24'h0, upper_ff[15:8]};
                dsp_bank_pkg::idx_lower_lo: prdata_ff <= {24'h0, lower_ff[7:0]};
                dsp_bank_pkg::idx_lower_hi: prdata_ff <= {24'h0, lower_ff[15:8]};
                dsp_bank_pkg::idx_control: prdata_ff <= {31'h0, control_ff[0]};
                dsp_bank_pkg::idx_status: prdata_ff <= {29'h0, status_ff};
                dsp_bank_pkg::idx_enable: prdata_ff <= {29'h0, enable_ff};
                default: prdata_ff <= 32'h0000_0000;
            endcase
        end
    end
    assign prdata = prdata_ff;
endmodule : dsp_offset_threshold_bank
`default_nettype wire

// file: tb/apb_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// ************************************************************
// host processor on the register bus
// ************************************************************
module apb_host_model (
    input wire logic pclk,
    input wire logic pready,
    input wire logic [31:0] prdata,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata
);
    // idle bus from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end
    // setup cycle, then access held until pready is seen high
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                        output logic [7:0] rd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata[7:0];
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        logic [7:0] d;
        xfer(1'b1, idx, wd, d);
    endtask : wr
    // low byte first, high byte at the next index; callers keep threshold values non-negative
    task automatic wr16(input logic [7:0] idx, input logic [15:0] v);
        wr(idx, v[7:0]);
        wr(idx + 8'h01, v[15:8]);
    endtask : wr16
    // copy the factory level into the transmit level
    task automatic init_gain();
        logic [7:0] d;
        xfer(1'b0, dsp_bank_pkg::idx_factory, 8'h00, d);
        wr(dsp_bank_pkg::idx_tx_level, d);
    endtask : init_gain
endmodule : apb_host_model
`default_nettype wire

// file: tb/dsp_bank_checker.sv
`timescale 1ns/1ns
`default_nettype none
// ************************************************************
// port checker for the offset and threshold bank
// ************************************************************
module dsp_bank_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sym_strobe,
    input wire logic [15:0] phase_detect,
    input wire logic [15:0] phase_to_loop,
    input wire logic [15:0] rx_format,
    input wire logic [15:0] rx_corrected,
    input wire logic [3:0] tx_gain_code,
    input wire logic [15:0] slicer_error,
    input wire logic noise_hit,
    input wire logic predictor_pause,
    input wire logic auto_sync_mode
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr_acc;
    // a write lands at the access edge
    assign wr_acc = psel && penable && pwrite;
    sequence wr_to(logic [7:0] idx);
        wr_acc && paddr[9:2] == idx;
    endsequence
    phase_hold_a: assert property ($stable(phase_detect) && !$past(wr_acc) |=> $stable(phase_to_loop))
        else $error("phase output moved without cause");
    dc_hold_a: assert property ($stable(rx_format) && !$past(wr_acc) |=> $stable(rx_corrected))
        else $error("receive output moved without cause");
    gain_write_a: assert property ($changed(tx_gain_code) |-> $past(wr_acc && paddr[9:2] == 8'h29))
        else $error("gain code changed without write");
    noise_strobe_a: assert property (noise_hit |-> sym_strobe && slicer_error != 16'h0000)
        else $error("noise hit outside a strobe");
    pause_start_a: assert property ($rose(predictor_pause) |-> $past(sym_strobe))
        else $error("pause began off a symbol");
    pause_end_a: assert property ($fell(predictor_pause) |-> $past(sym_strobe))
        else $error("pause ended off a symbol");
    mode_write_a: assert property ($changed(auto_sync_mode) |-> $past(wr_acc && paddr[9:2] == 8'h40))
        else $error("sync mode changed without write");
    pair_write_a: assert property (wr_to(8'h24) |=> $stable(tx_gain_code))
        else $error("phase write touched gain");
    rdata_hold_a: assert property (!$past(psel && !penable && !pwrite) |-> $stable(prdata))
        else $error("read data moved between reads");
    bus_ok_a: assert property (pready && !pslverr)
        else $error("bus answer not ready or in error");
endmodule : dsp_bank_checker
bind dsp_offset_threshold_bank dsp_bank_checker i_chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .prdata, .pready, .pslverr, .sym_strobe, .phase_detect, .phase_to_loop, .rx_format,
    .rx_corrected, .tx_gain_code, .slicer_error, .noise_hit, .predictor_pause, .auto_sync_mode);
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
// ************************************************************
// bench top
// ************************************************************
module testbench;
    logic pclk = 1'b0, presetn = 1'b0, psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] factory_gain = 4'hA, tx_gain_code;
    logic sym_strobe = 1'b0, match_bit = 1'b0, noise_hit, predictor_pause, auto_sync_mode;
    logic [15:0] phase_detect = 16'h0, rx_format = 16'h0, slicer_error = 16'h0;
    logic [15:0] far_end_level = 16'h0, phase_to_loop, rx_corrected;
    int error_cnt = 0, checks_done = 0, cycles = 0;
    dsp_offset_threshold_bank i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .factory_gain, .sym_strobe, .phase_detect, .phase_to_loop,
        .rx_format, .rx_corrected, .tx_gain_code, .slicer_error, .noise_hit, .predictor_pause,
        .match_bit, .auto_sync_mode, .far_end_level, .irq);
    apb_host_model i_host (.pclk, .pready, .prdata, .psel, .penable, .pwrite, .paddr, .pwdata);
    // 20 MHz clock and a cycle ceiling
    always #25 pclk = ~pclk;
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            stop_test();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] d;
        i_host.xfer(1'b0, idx, 8'h00, d);
        chk({8'h00, d}, {8'h00, exp});
    endtask : rd
    // pulse the symbol strobe n times, one cycle in two
    task automatic sym(input int n);
        repeat (n) begin
            @(posedge pclk) sym_strobe <= 1'b1;
            @(posedge pclk) sym_strobe <= 1'b0;
        end
    endtask : sym
    task automatic t_regs();
        logic [7:0] idx[6] = '{8'h24, 8'h26, 8'h2A, 8'h2C, 8'h30, 8'h32};
        rd(dsp_bank_pkg::idx_factory, {2'h0, factory_gain, 2'h0});
        i_host.wr(dsp_bank_pkg::idx_factory, 8'hFF);
        rd(dsp_bank_pkg::idx_factory, {2'h0, factory_gain, 2'h0});
        foreach (idx[i]) i_host.wr16(idx[i], {4'h1, 4'(i), 8'h5C});
        foreach (idx[i]) rd(idx[i], 8'h5C);
        foreach (idx[i]) rd(idx[i] + 8'h01, {4'h1, 4'(i)});
        i_host.wr(dsp_bank_pkg::idx_lock, 8'hFF);
        rd(dsp_bank_pkg::idx_lock, 8'h7F);
        rd(8'h3F, 8'h00);
    endtask : t_regs
    task automatic t_path();
        i_host.wr16(dsp_bank_pkg::idx_phase_lo, 16'h0010);
        i_host.wr16(dsp_bank_pkg::idx_dc_lo, 16'hFFF0);
        phase_detect <= 16'h0100;
        rx_format <= 16'h0020;
        repeat (3) @(posedge pclk);
        chk(phase_to_loop, 16'h00F0);
        chk(rx_corrected, 16'h0030);
    endtask : t_path
    task automatic t_gain();
        logic [3:0] code[3] = '{4'h8, 4'h0, 4'h7};
        i_host.init_gain();
        @(negedge pclk);
        chk(tx_gain_code, factory_gain);
        foreach (code[i]) begin
            i_host.wr(dsp_bank_pkg::idx_tx_level, {2'h0, code[i], 2'h0});
            @(negedge pclk) chk(tx_gain_code, code[i]);
        end
    endtask : t_gain
    task automatic t_noise();
        logic [15:0] err[4] = '{16'h0101, 16'h0100, 16'hFEFF, 16'hFF00};
        logic hit[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
        i_host.wr16(dsp_bank_pkg::idx_noise_lo, 16'h0100);
        foreach (err[i]) begin
            @(posedge pclk);
            slicer_error <= err[i];
            sym_strobe <= 1'b1;
            @(negedge pclk) chk(noise_hit, hit[i]);
            @(posedge pclk) sym_strobe <= 1'b0;
        end
        slicer_error <= 16'h0;
    endtask : t_noise
    task automatic t_pause();
        i_host.wr16(dsp_bank_pkg::idx_hold_lo, 16'h0100);
        slicer_error <= 16'h0101;
        sym(1);
        slicer_error <= 16'h0;
        sym(4);
        @(negedge pclk) chk(predictor_pause, 1'b1);
        sym(1);
        @(negedge pclk) chk(predictor_pause, 1'b0);
    endtask : t_pause
    task automatic t_alarm();
        i_host.wr(dsp_bank_pkg::idx_enable, 8'h07);
        i_host.wr16(dsp_bank_pkg::idx_upper_lo, 16'h0200);
        i_host.wr16(dsp_bank_pkg::idx_lower_lo, 16'h0180);
        far_end_level <= 16'h0180;
        i_host.wr(dsp_bank_pkg::idx_clear, 8'h07);
        rd(dsp_bank_pkg::idx_status, 8'h00);
        far_end_level <= 16'h0201;
        rd(dsp_bank_pkg::idx_status, 8'h02);
        chk(irq, 1'b1);
        far_end_level <= 16'h0200;
        i_host.wr(dsp_bank_pkg::idx_clear, 8'h02);
        rd(dsp_bank_pkg::idx_status, 8'h00);
        far_end_level <= 16'h017F;
        rd(dsp_bank_pkg::idx_status, 8'h04);
        i_host.wr(dsp_bank_pkg::idx_enable, 8'h00);
        @(negedge pclk) chk(irq, 1'b0);
        far_end_level <= 16'h0180;
        i_host.wr(dsp_bank_pkg::idx_clear, 8'h04);
        rd(dsp_bank_pkg::idx_status, 8'h00);
    endtask : t_alarm
    task automatic t_sync();
        match_bit <= 1'b1;
        sym(160);
        rd(dsp_bank_pkg::idx_status, 8'h00);
        i_host.wr(dsp_bank_pkg::idx_enable, 8'h01);
        i_host.wr(dsp_bank_pkg::idx_control, 8'h01);
        sym(160);
        rd(dsp_bank_pkg::idx_status, 8'h01);
        chk(auto_sync_mode, 1'b1);
        i_host.wr(dsp_bank_pkg::idx_clear, 8'h01);
        rd(dsp_bank_pkg::idx_status, 8'h01);
        chk(irq, 1'b1);
    endtask : t_sync
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : stop_test
    // reset for 5 cycles, then the scenarios
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        t_regs();
        t_path();
        t_gain();
        t_noise();
        t_pause();
        t_alarm();
        t_sync();
        stop_test();
    end
endmodule : testbench
`default_nettype wire
